//--- src/bus_gating.sv
// Purpose: target-bus gating, read-strobe policy and wait insertion
// Assumes: cpu-side inputs are on clk_i; jumper pins are asynchronous
// Notes:   switch positions are apb control bits; jumpers are pins
//
// Overview of operation
// [R1] position 1 off: release emulator data lines
// [R2] position 1 on: drive emulator data lines out
// [R3] 2 on, 3 off: always forward read strobe
// [R4] 2 off, 3 on: withhold strobe on emulator memory
// [R5] suppression only in first in-circuit mapping mode
// [R6] wait on: stretch each machine cycle fixed clocks
// [R7] wait off: no wait clocks inserted
// [R8] wait length two, jumpers select one or three
// [R9] positions 2 and 3 never both on
// [R10] hold wait request for selected clocks, release
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
module bus_gating
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        cycle_start_i,
  input  wire logic        cpu_tick_i,
  input  wire logic        cpu_rd_n_i,
  input  wire logic        emu_mem_hit_i,
  input  wire logic [7:0]  emu_data_i,
  input  wire logic        one_clock_jumper_point_i,
  input  wire logic        three_clock_jumper_point_i,
  output logic      [7:0]  emulator_data_lines_o,
  output logic             emulator_data_lines_oe_o,
  output logic             target_rd_n_o,
  output logic             wait_req_n_o
);
  logic [bus_gating_pkg::CTRL_W-1:0] ctrl_reg;
  logic [bus_gating_pkg::CTRL_W-1:0] ctrl_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic [7:0]  data_reg;
  logic        oe_reg;
  logic        rd_n_reg;
  logic        wait_n_reg;
  logic [7:0]  data_next;
  logic        oe_next;
  logic        rd_n_next;
  logic        wait_n_next;
  logic [2:0]  one_sync_reg;
  logic [2:0]  three_sync_reg;
  logic        one_stable_reg;
  logic        three_stable_reg;
  logic [bus_gating_pkg::LEN_W-1:0]  wait_len;
  logic [bus_gating_pkg::MODE_W-1:0] map_mode;
  logic        data_en;
  logic        rd_fwd;
  logic        rd_sup;
  logic        wait_en;
  logic        conflict;
  logic        suppress;
  logic        addr_ok;
  logic        write_done;

  wait_ctl_if wc ();

  wait_inserter u_wait
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .wc      (wc.unit)
  );

  assign data_en  = ctrl_reg[bus_gating_pkg::CTRL_DATA_EN_BIT];
  assign rd_fwd   = ctrl_reg[bus_gating_pkg::CTRL_RD_FWD_BIT];
  assign rd_sup   = ctrl_reg[bus_gating_pkg::CTRL_RD_SUP_BIT];
  assign wait_en  = ctrl_reg[bus_gating_pkg::CTRL_WAIT_EN_BIT];
  assign map_mode = ctrl_reg[bus_gating_pkg::CTRL_MODE_LSB +:
                             bus_gating_pkg::MODE_W];
  // both policies on is illegal; forwarding is kept as the safe reading
  assign conflict = rd_fwd && rd_sup; // R9
  assign suppress = rd_sup && !rd_fwd && emu_mem_hit_i // R4
                    && map_mode == bus_gating_pkg::MODE_EMU_MEM_MAP; // R5

  // jumpers: a change counts once stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      one_sync_reg     <= 3'h0;
      three_sync_reg   <= 3'h0;
      one_stable_reg   <= 1'b0;
      three_stable_reg <= 1'b0;
    end
    else
    begin
      one_sync_reg   <= {one_sync_reg[1:0], one_clock_jumper_point_i};
      three_sync_reg <= {three_sync_reg[1:0], three_clock_jumper_point_i};
      if (one_sync_reg[1] == one_sync_reg[2])
        one_stable_reg <= one_sync_reg[2];
      if (three_sync_reg[1] == three_sync_reg[2])
        three_stable_reg <= three_sync_reg[2];
    end
  end

  always_comb
  begin
    wait_len = bus_gating_pkg::WAIT_LEN_DEFAULT; // R8
    if (one_stable_reg)
      wait_len = bus_gating_pkg::WAIT_LEN_ONE;
    else if (three_stable_reg)
      wait_len = bus_gating_pkg::WAIT_LEN_THREE;
  end

  assign wc.cycle_start = cycle_start_i;
  assign wc.cpu_tick    = cpu_tick_i;
  assign wc.enable      = wait_en; // R6 R7
  assign wc.length      = wait_len;

  // apb slave: one wait state, answer in the second access cycle
  assign addr_ok = paddr_i == bus_gating_pkg::CTRL_ADDR
                   || paddr_i == bus_gating_pkg::STATUS_ADDR;
  assign write_done = psel_i && penable_i && pready_reg && pwrite_i;

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (psel_i && penable_i && !pready_reg)
    begin
      pready_next  = 1'b1;
      pslverr_next = !addr_ok;
      prdata_next  = 32'h0;
      if (!pwrite_i && paddr_i == bus_gating_pkg::CTRL_ADDR)
        prdata_next[bus_gating_pkg::CTRL_W-1:0] = ctrl_reg;
      else if (!pwrite_i && paddr_i == bus_gating_pkg::STATUS_ADDR)
      begin
        prdata_next[bus_gating_pkg::STAT_WAIT_BIT]     = wc.active;
        prdata_next[bus_gating_pkg::STAT_RD_BIT]       = rd_n_reg;
        prdata_next[bus_gating_pkg::STAT_CONFLICT_BIT] = conflict;
        prdata_next[bus_gating_pkg::STAT_LEN_LSB +:
                    bus_gating_pkg::LEN_W] = wait_len;
      end
    end
    if (write_done && paddr_i == bus_gating_pkg::CTRL_ADDR)
      ctrl_next = pwdata_i[bus_gating_pkg::CTRL_W-1:0];
  end

  always_comb
  begin
    data_next   = emu_data_i;
    oe_next     = data_en; // R1 R2
    rd_n_next   = cpu_rd_n_i || suppress; // R3 R4 R5
    wait_n_next = !wc.active; // R10
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_reg    <= bus_gating_pkg::CTRL_RESET;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      data_reg    <= 8'h00;
      oe_reg      <= 1'b0;
      rd_n_reg    <= 1'b1;
      wait_n_reg  <= 1'b1;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      data_reg    <= data_next;
      oe_reg      <= oe_next;
      rd_n_reg    <= rd_n_next;
      wait_n_reg  <= wait_n_next;
    end
  end

  assign prdata_o                 = prdata_reg;
  assign pready_o                 = pready_reg;
  assign pslverr_o                = pslverr_reg;
  assign emulator_data_lines_o    = data_reg;
  assign emulator_data_lines_oe_o = oe_reg;
  assign target_rd_n_o            = rd_n_reg;
  assign wait_req_n_o             = wait_n_reg;

  chk_data_release: assert property ( // R1
    @(posedge clk_i) disable iff (reset_i)
    !data_en |=> !emulator_data_lines_oe_o)
    else $error("data lines driven while disabled");
  chk_data_drive_out: assert property ( // R2
    @(posedge clk_i) disable iff (reset_i)
    data_en |=> (emulator_data_lines_oe_o
                 && emulator_data_lines_o == $past(emu_data_i)))
    else $error("data lines not driven while enabled");
  chk_rd_always_fwd: assert property ( // R3
    @(posedge clk_i) disable iff (reset_i)
    (rd_fwd && !rd_sup) |=> target_rd_n_o == $past(cpu_rd_n_i))
    else $error("read strobe not forwarded");
  chk_rd_withheld: assert property ( // R4
    @(posedge clk_i) disable iff (reset_i)
    (rd_sup && !rd_fwd && emu_mem_hit_i && !cpu_rd_n_i
     && map_mode == bus_gating_pkg::MODE_EMU_MEM_MAP) |=> target_rd_n_o)
    else $error("read strobe reached target on emulator access");
  chk_rd_other_mode: assert property ( // R5
    @(posedge clk_i) disable iff (reset_i)
    (map_mode != bus_gating_pkg::MODE_EMU_MEM_MAP) |=>
      target_rd_n_o == $past(cpu_rd_n_i))
    else $error("read strobe withheld outside first mapping mode");
  chk_wait_len_pick: assert property ( // R8
    @(posedge clk_i) disable iff (reset_i)
    (!one_stable_reg && !three_stable_reg) |->
      wait_len == bus_gating_pkg::WAIT_LEN_DEFAULT)
    else $error("wait length not two without jumper");
  chk_wait_pin_follow: assert property ( // R10
    @(posedge clk_i) disable iff (reset_i)
    wc.active |=> !wait_req_n_o)
    else $error("wait request pin not asserted");
  chk_apb_one_wait: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (psel_i && penable_i && !pready_o) |=> pready_o)
    else $error("apb answer late");
endmodule

//--- src/bus_gating_pkg.sv
// Purpose: shared constants for the emulator target-bus gating block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   switch positions live in the control register
package bus_gating_pkg;
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  // control register fields
  localparam int CTRL_DATA_EN_BIT  = 0;  // position 1
  localparam int CTRL_RD_FWD_BIT   = 1;  // position 2
  localparam int CTRL_RD_SUP_BIT   = 2;  // position 3
  localparam int CTRL_WAIT_EN_BIT  = 3;  // position 4
  localparam int CTRL_MODE_LSB     = 4;
  localparam int MODE_W            = 2;
  localparam logic [7:0] CTRL_RESET = 8'h0b;  // factory: 1,2,4 on, 3 off
  localparam int CTRL_W            = 8;
  // status register fields
  localparam int STAT_WAIT_BIT     = 0;
  localparam int STAT_RD_BIT       = 1;
  localparam int STAT_CONFLICT_BIT = 2;
  localparam int STAT_LEN_LSB      = 4;
  localparam int LEN_W             = 2;
  localparam logic [MODE_W-1:0] MODE_EMU_MEM_MAP = 2'h1;
  localparam logic [LEN_W-1:0] WAIT_LEN_ONE     = 2'h1;
  localparam logic [LEN_W-1:0] WAIT_LEN_DEFAULT = 2'h2;
  localparam logic [LEN_W-1:0] WAIT_LEN_THREE   = 2'h3;
endpackage

//--- src/wait_ctl_if.sv
// Purpose: carries wait requests between the top and the wait unit
// Assumes: all signals on clk_i
// Notes:   length is in emulated cpu clocks
`timescale 1ns/1ns
interface wait_ctl_if;
  logic                                 cycle_start;
  logic                                 cpu_tick;
  logic                                 enable;
  logic [bus_gating_pkg::LEN_W-1:0]     length;
  logic                                 active;
  modport ctl  (output cycle_start, output cpu_tick, output enable,
                output length, input active);
  modport unit (input cycle_start, input cpu_tick, input enable,
                input length, output active);
endinterface

//--- src/wait_inserter.sv
// Purpose: holds a wait request for a set number of cpu clocks per cycle
// Assumes: cycle_start is a one-cycle pulse at each machine cycle start
// Notes:   a new cycle start while holding is ignored
`timescale 1ns/1ns
module wait_inserter
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  wait_ctl_if.unit  wc
);
  typedef enum logic {IDLE, HOLD} wait_state_t;
  wait_state_t                      state_reg;
  wait_state_t                      state_next;
  logic [bus_gating_pkg::LEN_W-1:0] count_reg;
  logic [bus_gating_pkg::LEN_W-1:0] count_next;

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      IDLE:
      begin
        if (wc.cycle_start && wc.enable && wc.length != '0) // R6 R7
        begin
          state_next = HOLD;
          count_next = wc.length;
        end
      end
      HOLD:
      begin
        if (wc.cpu_tick) // R10
        begin
          count_next = count_reg - 2'h1;
          if (count_reg == 2'h1)
            state_next = IDLE;
        end
      end
      default:
        state_next = IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= IDLE;
      count_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign wc.active = (state_reg == HOLD);

  chk_wait_off_none: assert property ( // R7
    @(posedge clk_i) disable iff (reset_i)
    (state_reg == IDLE && wc.cycle_start && !wc.enable) |=> !wc.active)
    else $error("wait started while disabled");
  chk_wait_start_hold: assert property ( // R6
    @(posedge clk_i) disable iff (reset_i)
    (state_reg == IDLE && wc.cycle_start && wc.enable) |=>
      (wc.active && count_reg == $past(wc.length)))
    else $error("wait did not start with selected length");
  chk_wait_last_tick: assert property ( // R10
    @(posedge clk_i) disable iff (reset_i)
    (wc.active && wc.cpu_tick && count_reg == 2'h1) |=> !wc.active)
    else $error("wait not released after last clock");
  chk_wait_no_early: assert property ( // R10
    @(posedge clk_i) disable iff (reset_i)
    (wc.active && (!wc.cpu_tick || count_reg > 2'h1)) |=> wc.active)
    else $error("wait released early");
endmodule

//--- testbench/target_bus_model.sv
// Purpose: target side of the emulator data lines
// Assumes: emulator drives the lines only while oe is high
// Notes:   released lines flip every cycle, never hold the old value
`timescale 1ns/1ns
module target_bus_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] drive_i,
  input  wire logic       oe_i,
  output logic      [7:0] bus_o
);
  logic [7:0] park_reg;
  initial park_reg = 8'h00;
  // a floating bus must not look like a stale drive
  always @(posedge clk_i)
    park_reg <= ~bus_o;
  assign bus_o = oe_i ? drive_i : park_reg;
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the target-bus gating block
// Assumes: apb answers with one wait state, gating lags one cycle
// Notes:   read strobe policies are never both selected
`timescale 1ns/1ns
module tb_top;
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr;
  logic        serr, cyc, tick, cpu_rd_n, hit, j1, j3, oe, rd_n, wait_n;
  logic [7:0]  paddr, emu_data, lines, bus;
  logic [5:0]  v;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0]  pol_tab [3] = '{2'b01, 2'b10, 2'b00};
  logic [1:0]  jmp_tab [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  logic [1:0]  len_tab [4] = '{2'h2, 2'h1, 2'h3, 2'h1};
  int          fail_count, samples_checked, n;

  bus_gating bus_gating_i
  (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cycle_start_i(cyc), .cpu_tick_i(tick),
    .cpu_rd_n_i(cpu_rd_n), .emu_mem_hit_i(hit), .emu_data_i(emu_data),
    .one_clock_jumper_point_i(j1), .three_clock_jumper_point_i(j3),
    .emulator_data_lines_o(lines), .emulator_data_lines_oe_o(oe),
    .target_rd_n_o(rd_n), .wait_req_n_o(wait_n)
  );

  target_bus_model target_bus_model_i
  (
    .clk_i(clk_i), .drive_i(lines), .oe_i(oe), .bus_o(bus)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("mismatches=%0d compares=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic exp_rd(input logic [5:0] c);
    return cpu_rd_n | (c[2] & ~c[1] & hit &
                       (c[5:4] == bus_gating_pkg::MODE_EMU_MEM_MAP));
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge clk_i);
      w++;
    end
    while (pready !== 1'b1 && w < 20);
    if (w >= 20)
    begin
      fail_count++;
      end_of_test();
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  // counts cpu ticks needed before the wait request lets go
  task automatic measure(output int cnt);
    int w;
    cnt = 0;
    w = 0;
    cyc <= 1'b1;
    @(posedge clk_i);
    cyc <= 1'b0;
    while (wait_n !== 1'b0 && w < 4)
    begin
      @(negedge clk_i);
      w++;
    end
    while (wait_n === 1'b0 && cnt < 6)
    begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      cnt++;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
    end
    @(posedge clk_i);
  endtask

  initial
  begin
    void'($urandom(41));
    {reset_i, psel, penable, pwrite, cyc, tick, hit, j1, j3} = 9'h100;
    {paddr, pwdata, emu_data} = '0;
    cpu_rd_n = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    apb(1'b0, 8'h00, 32'h0);
    check(rdata, {24'h0, bus_gating_pkg::CTRL_RESET});
    apb(1'b0, 8'h04, 32'h0);
    check(rdata[5:4], 2'h2);
    apb(1'b0, 8'h08, 32'h0);
    check({serr, rdata[30:0]}, 32'h80000000);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, 8'h00, {28'h0, 3'b101, k[0]});
      emu_data <= 8'($urandom);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check(oe, k[0]);
      if (k[0])
        check(bus, emu_data);
      // next apb setup must start just after a rising edge
      @(posedge clk_i);
    end
    for (int i = 0; i < 12; i++)
    begin
      v = {i[1:0], 1'b1, pol_tab[i / 4], 1'b1};
      apb(1'b1, 8'h00, {26'h0, v});
      apb(1'b0, 8'h00, 32'h0);
      check(rdata, {26'h0, v});
      for (int r = 0; r < 4; r++)
      begin
        // first sample forces the corner: emulator hit with read low
        hit <= (r == 0) ? 1'b1 : 1'($urandom);
        cpu_rd_n <= (r == 0) ? 1'b0 : 1'($urandom);
        @(posedge clk_i);
        @(negedge clk_i);
        check(rd_n, exp_rd(v));
        @(posedge clk_i);
      end
    end
    for (int i = 0; i < 8; i++)
    begin
      {j1, j3} <= jmp_tab[i % 4];
      apb(1'b1, 8'h00, {28'h0, i[2], 3'b011});
      repeat (6) @(posedge clk_i);
      apb(1'b0, 8'h04, 32'h0);
      if (i[2])
        check(rdata[5:4], len_tab[i % 4]);
      measure(n);
      check(n, i[2] ? len_tab[i % 4] : 0);
    end
    end_of_test();
  end
endmodule
